//--- common/ukf_defs.svh
`ifndef UKF_DEFS_SVH
`define UKF_DEFS_SVH
// Overview of operation
// - mcast enable bit 31 set forwards unknown multicast to mask ports, clear drops.
// - mcast mask bit 0 is port 1, bit 1 port 2; all ones all ports.
// - vlan enable bit 31 set forwards unknown vid frames to mask ports.
// - vlan mask bit 0 is port 1 upward; set bit forwards, clear excludes.
// - several unknown categories: vid first, then unicast, then multicast.
// - alternate back-off bit 7 selects alternate scheme, half-duplex ports only.
// - unless excessive-collision drop disabled, drop frame at 16 or more collisions.
// - length check bit 3 discards frames with length below 1500 mismatching size.
// - flow-control drop mode set drops ethertype 8808 or pause address.
// - drop mode clear drops only frames with both pause type and address.
// - pass-flow-control enabled forwards pause frames instead of filtering.
// - aggressive back-off bit 0 enables non-standard half-duplex back-off.
`define UKF_MCAST_OFS    12'h324
`define UKF_VLAN_OFS     12'h328
`define UKF_MAC0_OFS     12'h330
`define UKF_UCAST_OFS    12'h320
`define UKF_EN_BIT       31
`define UKF_MAC0_RESET   8'h04
`define UKF_ALT_BIT      7
`define UKF_LEN_BIT      3
`define UKF_FCDROP_BIT   1
`define UKF_AGGR_BIT     0
`define UKF_LEN_LIMIT    16'h05dc
`define UKF_PAUSE_TYPE   16'h8808
`define UKF_PAUSE_DA     48'h0180c2000001
`define UKF_MAX_COLL     5'h10
`endif

//--- common/ukf_pkg.sv
package ukf_pkg;
  typedef enum logic [1:0] {
    ukf_cat_none_type_v,
    ukf_cat_vid_type_v,
    ukf_cat_ucast_type_v,
    ukf_cat_mcast_type_v
  } ukf_cat_type;
endpackage

//--- common/ukf_cfg_if.sv
interface ukf_cfg_if;
  logic       mcast_en;
  logic [6:0] mcast_mask;
  logic       vlan_en;
  logic [6:0] vlan_mask;
  logic [7:0] mac0;
  modport regs (output mcast_en, mcast_mask, vlan_en, vlan_mask, mac0);
  modport use_cfg (input mcast_en, mcast_mask, vlan_en, vlan_mask, mac0);
endinterface

//--- src/ukf_regs.sv
`include "ukf_defs.svh"
module ukf_regs
  import ukf_pkg::*;
(
  input  wire logic        clk,         // core clock
  input  wire logic        reset,       // sync reset
  input  wire logic [11:0] address,     // byte address
  input  wire logic        read,        // read request
  input  wire logic        write,       // write request
  input  wire logic [31:0] writedata,   // write data
  input  wire logic [3:0]  byteenable,  // byte lanes
  output logic [31:0]      readdata,    // read data
  output logic             waitrequest, // stall
  ukf_cfg_if.regs          cfg          // configuration out
);
  logic        mc_en, next_mc_en, vl_en, next_vl_en, ack, next_ack;
  logic [6:0]  mc_mask, next_mc_mask, vl_mask, next_vl_mask;
  logic [7:0]  mac0, next_mac0;
  logic [31:0] rd, next_rd;

  // one wait cycle per access, then acknowledge
  always_comb begin
    next_mc_en   = mc_en;
    next_mc_mask = mc_mask;
    next_vl_en   = vl_en;
    next_vl_mask = vl_mask;
    next_mac0    = mac0;
    next_rd      = 32'h0000_0000;
    next_ack     = (read | write) & ~ack;
    // commit only at the edge where waitrequest is seen low
    if (write && ack) begin
      // reserved 30:7 ignored on write
      unique case (address)
        `UKF_MCAST_OFS: begin
          if (byteenable[3]) next_mc_en = writedata[`UKF_EN_BIT];
          if (byteenable[0]) next_mc_mask = writedata[6:0];
        end
        `UKF_VLAN_OFS: begin
          if (byteenable[3]) next_vl_en = writedata[`UKF_EN_BIT];
          if (byteenable[0]) next_vl_mask = writedata[6:0];
        end
        `UKF_MAC0_OFS: if (byteenable[0]) next_mac0 = writedata[7:0];
        default: ;
      endcase
    end
    if (read && !ack) begin
      unique case (address)
        `UKF_MCAST_OFS: next_rd = {mc_en, 24'h00_0000, mc_mask};
        `UKF_VLAN_OFS:  next_rd = {vl_en, 24'h00_0000, vl_mask};
        `UKF_MAC0_OFS:  next_rd = {24'h00_0000, mac0};
        default:        next_rd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mc_en <= 1'b0; mc_mask <= 7'h00; vl_en <= 1'b0; vl_mask <= 7'h00;
      mac0 <= `UKF_MAC0_RESET; ack <= 1'b0; rd <= 32'h0000_0000;
    end else begin
      mc_en <= next_mc_en; mc_mask <= next_mc_mask;
      vl_en <= next_vl_en; vl_mask <= next_vl_mask;
      mac0 <= next_mac0; ack <= next_ack; rd <= next_rd;
    end
  end

  assign waitrequest   = (read | write) & ~ack;
  assign readdata      = rd;
  assign cfg.mcast_en  = mc_en;
  assign cfg.mcast_mask = mc_mask;
  assign cfg.vlan_en   = vl_en;
  assign cfg.vlan_mask = vl_mask;
  assign cfg.mac0      = mac0;

  // written mac0 value is held in the register at the edge after the write commits
  rd_back_a: assert property (@(posedge clk) disable iff (reset)
    (write && !waitrequest && address == `UKF_MAC0_OFS && byteenable[0])
    |=> (mac0 == $past(writedata[7:0])))
    else $error("mac control write lost");
  rsv_zero_a: assert property (@(posedge clk) disable iff (reset)
    (read && !waitrequest && address == `UKF_MCAST_OFS)
    |-> (readdata[30:7] == 24'h00_0000))
    else $error("reserved bits not zero");
endmodule

//--- src/ukf_top.sv
// The Avalon-MM register port is this design's own decision.
`include "ukf_defs.svh"
module ukf_top
  import ukf_pkg::*;
(
  input  wire logic        clk,            // core clock
  input  wire logic        reset,          // sync reset
  input  wire logic [11:0] address,        // avalon byte address
  input  wire logic        read,           // avalon read
  input  wire logic        write,          // avalon write
  input  wire logic [31:0] writedata,      // avalon write data
  input  wire logic [3:0]  byteenable,     // avalon byte lanes
  output logic [31:0]      readdata,       // avalon read data
  output logic             waitrequest,    // avalon stall
  input  wire logic        frm_valid,      // frame descriptor valid
  input  wire logic        unk_vid,        // vid unknown
  input  wire logic        unk_ucast,      // unicast da unknown
  input  wire logic        unk_mcast,      // multicast da unknown
  input  wire logic [6:0]  ucast_ports,    // ports from unicast logic
  input  wire logic [15:0] type_len,       // ethertype or length
  input  wire logic [15:0] payload_len,    // measured length
  input  wire logic [47:0] dest_addr,      // destination address
  input  wire logic        pass_fc,        // pass pause frames
  input  wire logic        no_coll_drop,   // keep excessive collisions
  input  wire logic [4:0]  coll_count,     // collisions of a frame
  input  wire logic [6:0]  half_duplex,    // per-port half duplex
  output logic             dec_valid,      // decision valid
  output logic [6:0]       dec_ports,      // egress port mask
  output logic             dec_drop,       // drop frame
  output logic [1:0]       dec_cat,        // category taken
  output logic             coll_drop,      // drop after collisions
  output logic [6:0]       alt_backoff,    // alternate back-off per port
  output logic [6:0]       aggr_backoff    // aggressive back-off per port
);
  ukf_cfg_if cfg ();
  logic        is_pause_t, is_pause_da, fc_drop, len_bad, v, next_v;
  logic        drop, next_drop;
  logic [6:0]  ports, next_ports;
  ukf_cat_type cat, next_cat;

  ukf_regs u_regs (
    .clk         (clk),
    .reset       (reset),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .cfg         (cfg.regs)
  );

  // pause frame classification
  assign is_pause_t  = (type_len == `UKF_PAUSE_TYPE);
  assign is_pause_da = (dest_addr == `UKF_PAUSE_DA);
  always_comb begin
    if (pass_fc)
      fc_drop = 1'b0;
    else if (cfg.mac0[`UKF_FCDROP_BIT])
      fc_drop = is_pause_t | is_pause_da;
    else
      fc_drop = is_pause_t & is_pause_da;
  end
  // length check only for length-coded frames
  assign len_bad = cfg.mac0[`UKF_LEN_BIT] && (type_len < `UKF_LEN_LIMIT)
                   && (type_len != payload_len);

  // forwarding decision, vid wins over unicast over multicast
  always_comb begin
    next_v     = frm_valid;
    next_ports = 7'h7f;
    next_cat   = ukf_cat_none_type_v;
    next_drop  = fc_drop | len_bad;
    if (unk_vid) begin
      next_cat   = ukf_cat_vid_type_v;
      next_ports = cfg.vlan_en ? cfg.vlan_mask : 7'h00;
    end else if (unk_ucast) begin
      next_cat   = ukf_cat_ucast_type_v;
      next_ports = ucast_ports;
    end else if (unk_mcast) begin
      next_cat   = ukf_cat_mcast_type_v;
      next_ports = cfg.mcast_en ? cfg.mcast_mask : 7'h00;
    end
    if (next_drop) next_ports = 7'h00;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      v <= 1'b0; ports <= 7'h00; drop <= 1'b0; cat <= ukf_cat_none_type_v;
    end else begin
      v <= next_v; ports <= next_ports; drop <= next_drop; cat <= next_cat;
    end
  end

  assign dec_valid = v;
  assign dec_ports = ports;
  assign dec_drop  = drop;
  assign dec_cat   = cat;
  // mac-side options, back-off only touches half-duplex ports
  assign coll_drop    = !no_coll_drop && (coll_count >= `UKF_MAX_COLL);
  assign alt_backoff  = {7{cfg.mac0[`UKF_ALT_BIT]}} & half_duplex;
  assign aggr_backoff = {7{cfg.mac0[`UKF_AGGR_BIT]}} & half_duplex;

  mc_fwd_a: assert property (@(posedge clk) disable iff (reset)
    (frm_valid && !unk_vid && !unk_ucast && unk_mcast && !next_drop)
    |=> (dec_ports == ($past(cfg.mcast_en) ? $past(cfg.mcast_mask) : 7'h00)))
    else $error("multicast ports wrong");
  vid_first_a: assert property (@(posedge clk) disable iff (reset)
    (unk_vid && !next_drop) |=> (dec_cat == 2'(ukf_cat_vid_type_v)) &&
    (dec_ports == ($past(cfg.vlan_en) ? $past(cfg.vlan_mask) : 7'h00)))
    else $error("vid precedence wrong");
  fc_either_a: assert property (@(posedge clk) disable iff (reset)
    (!pass_fc && cfg.mac0[1] && (is_pause_t || is_pause_da)) |=> dec_drop)
    else $error("pause frame not dropped");
  fc_both_a: assert property (@(posedge clk) disable iff (reset)
    (!cfg.mac0[1] && is_pause_t != is_pause_da && !len_bad) |=> !dec_drop)
    else $error("partial pause frame dropped");
  fc_pass_a: assert property (@(posedge clk) disable iff (reset)
    (pass_fc && !len_bad) |=> !dec_drop)
    else $error("pause passed frame dropped");
  len_chk_a: assert property (@(posedge clk) disable iff (reset)
    (cfg.mac0[3] && type_len < 16'd1500 && type_len != payload_len)
    |=> (dec_drop && dec_ports == 7'h00))
    else $error("length mismatch kept");
  coll_lim_a: assert property (@(posedge clk) disable iff (reset)
    coll_drop == (!no_coll_drop && coll_count > 5'd15))
    else $error("collision drop wrong");
  bo_half_a: assert property (@(posedge clk) disable iff (reset)
    ((alt_backoff | aggr_backoff) & ~half_duplex) == 7'h00)
    else $error("backoff on full duplex port");
  aggr_bit_a: assert property (@(posedge clk) disable iff (reset)
    aggr_backoff == (cfg.mac0[0] ? half_duplex : 7'h00))
    else $error("aggressive backoff wrong");
  vl_mask_a: assert property (@(posedge clk) disable iff (reset)
    (unk_vid && cfg.vlan_en && !next_drop)
    |=> dec_ports == $past(cfg.vlan_mask))
    else $error("vlan mask wrong");
  mc_mask_a: assert property (@(posedge clk) disable iff (reset)
    (!unk_vid && !unk_ucast && unk_mcast && cfg.mcast_en && !next_drop)
    |=> dec_ports == $past(cfg.mcast_mask))
    else $error("multicast mask wrong");
  vl_off_a: assert property (@(posedge clk) disable iff (reset)
    (unk_vid && !cfg.vlan_en) |=> dec_ports == 7'h00)
    else $error("vlan forwarded while off");
endmodule

//--- testbench/ukf_fabric_model.sv
module ukf_fabric_model (
  input  wire logic        clk,         // core clock
  output logic             frm_valid,   // descriptor valid
  output logic             unk_vid,     // vid unknown
  output logic             unk_ucast,   // unicast unknown
  output logic             unk_mcast,   // multicast unknown
  output logic [6:0]       ucast_ports, // unicast port set
  output logic [15:0]      type_len,    // ethertype or length
  output logic [15:0]      payload_len, // measured length
  output logic [47:0]      dest_addr    // destination address
);
  timeunit 1ns;
  timeprecision 1ps;
  // fixed unicast set and frame length keep the call short
  initial begin
    {frm_valid, unk_vid, unk_ucast, unk_mcast} = 4'h0;
    ucast_ports = 7'h2a;
    type_len = 16'h0800;
    payload_len = 16'h0064;
    dest_addr = 48'h000000000000;
  end
  // held two edges, so either sampling edge sees it; result settles by #1
  task automatic send(input logic [2:0] unk, input logic [15:0] tl,
                      input logic [47:0] da);
    @(posedge clk);
    frm_valid <= 1'b1;
    {unk_vid, unk_ucast, unk_mcast} <= unk;
    type_len <= tl;
    dest_addr <= da;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule

//--- testbench/test_unknown_frame_forward_filter.sv
module test_unknown_frame_forward_filter;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic [11:0] address = 12'h000;
  logic [31:0] writedata = 32'h0, readdata;
  logic [3:0]  byteenable = 4'hf;
  logic waitrequest, frm_valid, unk_vid, unk_ucast, unk_mcast;
  logic [6:0] ucast_ports, dec_ports, alt_backoff, aggr_backoff;
  logic [15:0] type_len, payload_len;
  logic [47:0] dest_addr;
  logic pass_fc = 1'b0, no_coll_drop = 1'b0, dec_valid, dec_drop, coll_drop;
  logic [4:0] coll_count = 5'h00;
  logic [6:0] half_duplex = 7'h00;
  logic [1:0] dec_cat;
  int fail_count = 0, samples_checked = 0;
  localparam logic [47:0] PDA = 48'h0180c2000001, MDA = 48'h01005e000001;
  always #5 clk = ~clk;
  ukf_fabric_model fab (.clk(clk), .frm_valid(frm_valid), .unk_vid(unk_vid),
    .unk_ucast(unk_ucast), .unk_mcast(unk_mcast), .ucast_ports(ucast_ports),
    .type_len(type_len), .payload_len(payload_len), .dest_addr(dest_addr));
  ukf_top uut (.clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .frm_valid(frm_valid),
    .unk_vid(unk_vid), .unk_ucast(unk_ucast), .unk_mcast(unk_mcast),
    .ucast_ports(ucast_ports), .type_len(type_len),
    .payload_len(payload_len), .dest_addr(dest_addr), .pass_fc(pass_fc),
    .no_coll_drop(no_coll_drop), .coll_count(coll_count),
    .half_duplex(half_duplex), .dec_valid(dec_valid),
    .dec_ports(dec_ports), .dec_drop(dec_drop), .dec_cat(dec_cat),
    .coll_drop(coll_drop), .alt_backoff(alt_backoff),
    .aggr_backoff(aggr_backoff));
  task automatic chk(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    // one wait state per access, so the answer comes at the second edge
    chk(32'(n), 32'h2, "bus latency");
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, "readback");
  endtask
  // ports only matter once a category or a drop decides them
  task automatic dchk(input logic [2:0] unk, input logic [15:0] tl,
    input logic [47:0] da, input logic drop, input logic [1:0] cat,
    input logic [6:0] ports);
    fab.send(unk, tl, da);
    chk(32'(dec_valid), 32'h1, "valid");
    chk(32'(dec_drop), 32'(drop), "drop");
    chk(32'(dec_cat), 32'(cat), "category");
    if (cat != 2'h0 || drop)
      chk(32'(dec_ports), 32'(ports), "ports");
  endtask
  task automatic t_regs;
    rchk(12'h324, 32'h0);
    rchk(12'h328, 32'h0);
    rchk(12'h330, 32'h4);
    wr(12'h324, 32'hffffffff);
    wr(12'h328, 32'h7fffff81);
    wr(12'h33c, 32'hffffffff);
    rchk(12'h324, 32'h8000007f);
    rchk(12'h328, 32'h00000001);
    rchk(12'h33c, 32'h0);
    // low lane only: enable bit must keep its value
    @(posedge clk);
    byteenable <= 4'h1;
    wr(12'h328, 32'hffffff80);
    byteenable <= 4'hf;
    rchk(12'h328, 32'h00000000);
    $display("test regs done");
  endtask
  task automatic t_fwd;
    dchk(3'b001, 16'h0800, MDA, 1'b0, 2'h3, 7'h7f);
    dchk(3'b100, 16'h0800, MDA, 1'b0, 2'h1, 7'h00);
    wr(12'h328, 32'h80000041);
    dchk(3'b100, 16'h0800, MDA, 1'b0, 2'h1, 7'h41);
    dchk(3'b111, 16'h0800, MDA, 1'b0, 2'h1, 7'h41);
    dchk(3'b011, 16'h0800, MDA, 1'b0, 2'h2, 7'h2a);
    wr(12'h324, 32'h00000001);
    dchk(3'b001, 16'h0800, MDA, 1'b0, 2'h3, 7'h00);
    wr(12'h324, 32'h80000001);
    dchk(3'b001, 16'h0800, MDA, 1'b0, 2'h3, 7'h01);
    wr(12'h324, 32'h80000000);
    dchk(3'b001, 16'h0800, MDA, 1'b0, 2'h3, 7'h00);
    $display("test forward done");
  endtask
  task automatic t_filt;
    wr(12'h330, 32'h06);
    rchk(12'h330, 32'h06);
    dchk(3'b000, 16'h8808, MDA, 1'b1, 2'h0, 7'h0);
    dchk(3'b000, 16'h0800, PDA, 1'b1, 2'h0, 7'h0);
    wr(12'h330, 32'h04);
    dchk(3'b000, 16'h8808, MDA, 1'b0, 2'h0, 7'h0);
    dchk(3'b000, 16'h0800, PDA, 1'b0, 2'h0, 7'h0);
    dchk(3'b000, 16'h8808, PDA, 1'b1, 2'h0, 7'h0);
    @(posedge clk);
    pass_fc <= 1'b1;
    dchk(3'b000, 16'h8808, PDA, 1'b0, 2'h0, 7'h0);
    @(posedge clk);
    pass_fc <= 1'b0;
    wr(12'h330, 32'h0c);
    dchk(3'b000, 16'h005a, MDA, 1'b1, 2'h0, 7'h0);
    dchk(3'b000, 16'h0064, MDA, 1'b0, 2'h0, 7'h0);
    dchk(3'b000, 16'h05db, MDA, 1'b1, 2'h0, 7'h0);
    dchk(3'b000, 16'h05dc, MDA, 1'b0, 2'h0, 7'h0);
    wr(12'h330, 32'h04);
    dchk(3'b000, 16'h005a, MDA, 1'b0, 2'h0, 7'h0);
    $display("test filter done");
  endtask
  // collision outputs are combinational, so look just after the edge
  task automatic coll(input logic keep, input logic [4:0] n, input logic e);
    @(posedge clk);
    no_coll_drop <= keep;
    coll_count <= n;
    @(posedge clk);
    #1;
    chk(32'(coll_drop), 32'(e), "collision drop");
  endtask
  task automatic t_coll;
    @(posedge clk);
    half_duplex <= 7'h05;
    wr(12'h330, 32'h85);
    coll(1'b1, 5'h10, 1'b0);
    chk(32'(alt_backoff), 32'h05, "alternate");
    chk(32'(aggr_backoff), 32'h05, "aggressive");
    wr(12'h330, 32'h04);
    coll(1'b0, 5'h10, 1'b1);
    chk(32'(alt_backoff), 32'h00, "alternate off");
    chk(32'(aggr_backoff), 32'h00, "aggressive off");
    coll(1'b0, 5'h0f, 1'b0);
    coll(1'b0, 5'h1f, 1'b1);
    $display("test collision done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // whole run is about 140 cycles; this is ample margin
  initial begin
    #50000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report;
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_fwd;
    t_filt;
    t_coll;
    final_report;
  end
endmodule
